// >>> verilog/pwp_pkg.sv
// Package for the pixel write packer: widths, codes, carriers
package pwp_pkg;
  localparam int BYTE_W  = 8;
  localparam int PIX_W   = 12;
  localparam int NIB_W   = 4;
  localparam int LUT_LEN = 20;   // Colour table bytes: 8 red, 8 green, 4 blue
  localparam int RG_LEN  = 8;
  localparam logic [7:0] CMD_MEM_WRITE  = 8'h2c;
  localparam logic [7:0] CMD_COLOUR_SET = 8'h2d;
  localparam logic [1:0] PH_FIRST  = 2'h0;
  localparam logic [1:0] PH_SECOND = 2'h1;
  localparam logic [1:0] PH_THIRD  = 2'h2;
  localparam logic [4:0] LUT_LAST  = 5'h13;

  typedef enum logic [1:0] {
    PWP_IDLE  = 2'b00,
    PWP_WRITE = 2'b01,
    PWP_TABLE = 2'b10
  } pwp_mode_e;

  // One byte from the host port, data or command
  typedef struct packed {
    logic       valid;
    logic       data_command_select;
    logic [7:0] value;
  } pwp_byte_s;

  // One pixel toward display memory
  typedef struct packed {
    logic        valid;
    logic [11:0] rgb;
  } pwp_pix_s;
endpackage

// >>> verilog/pwp_lut.sv
// Colour table for 8-bit mode: loaded bytes, 332 expansion to 12 bits
`timescale 1ns/1ps
`default_nettype none
module pwp_lut #(
  parameter int DEPTH = pwp_pkg::LUT_LEN
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       load,
  input  wire logic [4:0] load_idx,
  input  wire logic [7:0] load_val,
  input  wire logic [7:0] pix_in,
  output logic [11:0]     pix_out
);
  logic [3:0] table_mem [DEPTH];

  // Low nibble of each colour-table byte holds the level
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DEPTH; i++) table_mem[i] <= 4'h0;
    end else if (load) begin
      table_mem[load_idx] <= load_val[3:0];
    end
  end

  // Red 3 bits, green 3 bits, blue 2 bits index three sub-tables
  always_comb begin
    pix_out = {table_mem[{2'h0, pix_in[7:5]}],
               table_mem[5'(pwp_pkg::RG_LEN) + {2'h0, pix_in[4:2]}],
               table_mem[5'(2 * pwp_pkg::RG_LEN) + {3'h0, pix_in[1:0]}]};
  end
endmodule
`default_nettype wire

// >>> verilog/pwp_packer.sv
// Pixel write packer: host display bytes to 12-bit display memory words
`timescale 1ns/1ps
`default_nettype none
// Bytes are taken on a rising edge with valid high; the pixel word
// follows one cycle after the byte that completes it
module pwp_packer (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              mode_8bit,
  input  wire pwp_pkg::pwp_byte_s host_byte,
  output pwp_pkg::pwp_pix_s      pix,
  output logic                   table_busy
);
  typedef struct packed {
    pwp_pkg::pwp_mode_e mode;
    logic [1:0]         phase;
    logic [3:0]         hold_r;
    logic [3:0]         hold_g;
    logic [4:0]         lut_idx;
    pwp_pkg::pwp_pix_s  pix;
  } pwp_state_s;

  // Registered state, its next image and per-byte helpers
  pwp_state_s         st;
  pwp_state_s         next_st;
  logic [11:0]        lut_pix;
  logic               lut_load;
  logic               is_data;
  logic               is_cmd;
  logic               table_end;
  logic [3:0]         hi;
  logic [3:0]         lo;
  logic [11:0]        even_rgb;
  logic [11:0]        odd_rgb;
  pwp_pkg::pwp_mode_e cmd_mode;

  // Reset image: idle, first byte of a group expected, no pixel pending
  localparam pwp_state_s ST_RESET = '{
    mode:    pwp_pkg::PWP_IDLE,
    phase:   pwp_pkg::PH_FIRST,
    hold_r:  4'h0,
    hold_g:  4'h0,
    lut_idx: 5'h00,
    pix:     '{valid: 1'b0, rgb: 12'h000}
  };

  // Field positions inside a host byte
  localparam int HI_MSB = pwp_pkg::BYTE_W - 1;
  localparam int HI_LSB = pwp_pkg::BYTE_W - pwp_pkg::NIB_W;
  localparam int LO_MSB = pwp_pkg::NIB_W - 1;

  // Upper nibble: the first colour carried by each byte
  function automatic logic [3:0] f_hi_nibble(input logic [7:0] b);
    return b[HI_MSB:HI_LSB];
  endfunction

  // Lower nibble: the second colour carried by each byte
  function automatic logic [3:0] f_lo_nibble(input logic [7:0] b);
    return b[LO_MSB:0];
  endfunction

  // Command to mode; unknown commands park it so stray data is refused
  function automatic pwp_pkg::pwp_mode_e f_cmd_mode(input logic [7:0] code);
    pwp_pkg::pwp_mode_e m;
    if (code == pwp_pkg::CMD_MEM_WRITE) begin
      m = pwp_pkg::PWP_WRITE;
    end else if (code == pwp_pkg::CMD_COLOUR_SET) begin
      m = pwp_pkg::PWP_TABLE;
    end else begin
      m = pwp_pkg::PWP_IDLE;
    end
    return m;
  endfunction

  // Even pixel: red and green held from byte one, blue from byte two
  function automatic logic [11:0] f_pack_even(input logic [3:0] r,
                                              input logic [3:0] g,
                                              input logic [7:0] b);
    logic [3:0] blue;
    blue = f_hi_nibble(b);
    return {r, g, blue};
  endfunction

  // Odd pixel: red held from byte two, green and blue are byte three
  function automatic logic [11:0] f_pack_odd(input logic [3:0] r,
                                             input logic [7:0] gb);
    logic [3:0] green;
    logic [3:0] blue;
    green = f_hi_nibble(gb);
    blue  = f_lo_nibble(gb);
    return {r, green, blue};
  endfunction

  // Position in the three-byte group after one more data byte
  function automatic logic [1:0] f_next_phase(input logic [1:0] ph);
    logic [1:0] nxt;
    case (ph)
      pwp_pkg::PH_FIRST:  nxt = pwp_pkg::PH_SECOND;
      pwp_pkg::PH_SECOND: nxt = pwp_pkg::PH_THIRD;
      default:            nxt = pwp_pkg::PH_FIRST;
    endcase
    return nxt;
  endfunction

  // Last table slot; loading stops there so extra bytes cannot wrap
  function automatic logic f_table_end(input logic [4:0] idx);
    return idx == pwp_pkg::LUT_LAST;
  endfunction

  // Next colour-table slot while loading
  function automatic logic [4:0] f_lut_next(input logic [4:0] idx);
    return idx + 5'h01;
  endfunction

  // Data and command bytes arrive from the one host port through one path
  assign is_data   = host_byte.valid && host_byte.data_command_select;
  assign is_cmd    = host_byte.valid && !host_byte.data_command_select;
  assign hi        = f_hi_nibble(host_byte.value);
  assign lo        = f_lo_nibble(host_byte.value);
  assign lut_load  = is_data && (st.mode == pwp_pkg::PWP_TABLE);
  assign table_end = f_table_end(st.lut_idx);
  assign cmd_mode  = f_cmd_mode(host_byte.value);

  // Pixel words ready to commit, from held nibbles and this byte
  assign even_rgb  = f_pack_even(st.hold_r, st.hold_g, host_byte.value);
  assign odd_rgb   = f_pack_odd(st.hold_r, host_byte.value);

  pwp_lut #(
    .DEPTH (pwp_pkg::LUT_LEN)
  ) u_lut (
    .clk      (clk),
    .arst_n   (arst_n),
    .load     (lut_load),
    .load_idx (st.lut_idx),
    .load_val (host_byte.value),
    .pix_in   (host_byte.value),
    .pix_out  (lut_pix)
  );

  // Command tracking and byte packing: one next-state image per cycle
  always_comb begin
    next_st           = st;
    next_st.pix.valid = 1'b0;  // Strobe lasts one cycle
    if (is_cmd) begin
      // Any command restarts grouping; partial pixel dropped
      next_st.phase   = pwp_pkg::PH_FIRST;
      next_st.lut_idx = 5'h00;
      next_st.mode    = cmd_mode;
    end else if (is_data) begin
      case (st.mode)
        pwp_pkg::PWP_TABLE: begin
          // Colour table fill, one slot per data byte
          if (table_end) begin
            next_st.mode = pwp_pkg::PWP_IDLE;
          end else begin
            next_st.lut_idx = f_lut_next(st.lut_idx);
          end
        end
        pwp_pkg::PWP_WRITE: begin
          if (mode_8bit) begin
            // One byte, one pixel, through the colour table
            next_st.pix.valid = 1'b1;
            next_st.pix.rgb   = lut_pix;
          end else begin
            // Group position advances on every data byte
            next_st.phase = f_next_phase(st.phase);
            case (st.phase)
              pwp_pkg::PH_FIRST: begin
                // Even red and green wait for blue; nothing written
                next_st.hold_r = hi;
                next_st.hold_g = lo;
              end
              pwp_pkg::PH_SECOND: begin
                // Even pixel complete; keep the odd pixel's red
                next_st.pix.valid = 1'b1;
                next_st.pix.rgb   = even_rgb;
                next_st.hold_r    = lo;
              end
              default: begin
                // Odd pixel complete; the group is closed
                next_st.pix.valid = 1'b1;
                next_st.pix.rgb   = odd_rgb;
              end
            endcase
          end
        end
        pwp_pkg::PWP_IDLE: begin
          // Data without a memory write command is refused
          next_st.phase = st.phase;
        end
        default: begin
          // Unused mode code: hold everything
          next_st.phase = st.phase;
        end
      endcase
    end
  end

  // State register; reset also abandons any table load in progress
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign pix        = st.pix;
  assign table_busy = (st.mode == pwp_pkg::PWP_TABLE);
endmodule
`default_nettype wire

// >>> sim/pwp_checker.sv
// Checker for the pixel write packer, bound to its ports
`timescale 1ns/1ps
`default_nettype none
module pwp_checker (
  input wire logic               clk,
  input wire logic               arst_n,
  input wire logic               mode_8bit,
  input wire pwp_pkg::pwp_byte_s host_byte,
  input wire pwp_pkg::pwp_pix_s  pix,
  input wire logic               table_busy
);
  logic        wr;
  logic        d;
  logic        c;
  logic [1:0]  ph;
  logic [7:0]  lb;
  logic [11:0] ev;
  logic [11:0] od;
  assign d  = host_byte.valid & host_byte.data_command_select;
  assign c  = host_byte.valid & ~host_byte.data_command_select;
  assign ev = {lb, host_byte.value[7:4]};
  assign od = {lb[3:0], host_byte.value};
  // Shadow of write session and byte phase in the group
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr <= 1'b0;
      ph <= 2'h0;
      lb <= 8'h00;
    end else begin
      if (c) wr <= (host_byte.value == pwp_pkg::CMD_MEM_WRITE);
      if (c) ph <= 2'h0;
      else if (d && wr && !mode_8bit) ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      if (d) lb <= host_byte.value;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_pix_cause: assert property (pix.valid |-> $past(d))
    else $error("pixel without data byte");
  a_busy_rise: assert property (c && host_byte.value ==
    pwp_pkg::CMD_COLOUR_SET |=> table_busy) else $error("no busy");
  a_busy_quiet: assert property (table_busy |=> !pix.valid)
    else $error("pixel during table load");
  a_eight_each: assert property (wr && mode_8bit && d |=> pix.valid)
    else $error("8-bit byte gave no pixel");
  a_first_quiet: assert property (wr && !mode_8bit && d && ph == 2'h0
    |=> !pix.valid) else $error("lone byte wrote");
  a_later_write: assert property (wr && !mode_8bit && d && ph != 2'h0
    |=> pix.valid) else $error("group pixel missing");
  a_pack_even: assert property (wr && !mode_8bit && d && ph == 2'h1
    |=> pix.rgb == $past(ev)) else $error("even pixel wrong");
  a_pack_odd: assert property (wr && !mode_8bit && d && ph == 2'h2
    |=> pix.rgb == $past(od)) else $error("odd pixel wrong");
  c_pair: cover property (pix.valid ##1 pix.valid);
  c_eight: cover property (mode_8bit && pix.valid);
  c_busy: cover property (table_busy);
endmodule
bind pwp_packer pwp_checker i_chk (.clk(clk), .arst_n(arst_n),
  .mode_8bit(mode_8bit), .host_byte(host_byte), .pix(pix),
  .table_busy(table_busy));
`default_nettype wire

// >>> sim/pwp_host.sv
// Host model: one byte per call, back to back when called in a row
`timescale 1ns/1ps
`default_nettype none
module pwp_host (
  input  wire logic          clk,
  output pwp_pkg::pwp_byte_s hb
);
  initial hb = '0;
  // Byte order within a group is the caller's: R0G0, B0R1, G1B1
  task automatic send(input logic dc, input logic [7:0] v);
    @(negedge clk);
    hb = {1'b1, dc, v};
  endtask
  // Released bus shows inverted lines, never the last byte
  task automatic idle();
    @(negedge clk);
    hb = {1'b0, ~hb.data_command_select, ~hb.value};
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Testbench: host model sends bytes, pixels are gathered and compared
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic               clk = 1'b0;
  logic               arst_n = 1'b0;
  logic               mode_8bit = 1'b0;
  pwp_pkg::pwp_byte_s hb;
  pwp_pkg::pwp_pix_s  pix;
  logic               table_busy;
  logic [11:0]        got[$];
  int                 n_fail = 0;
  int                 checks_done = 0;
  int                 cyc = 0;
  always #12.5 clk = ~clk;
  pwp_host   i_host (.clk(clk), .hb(hb));
  pwp_packer i_dut (.clk(clk), .arst_n(arst_n), .mode_8bit(mode_8bit),
    .host_byte(hb), .pix(pix), .table_busy(table_busy));
  // Gather pixel writes; exact cycles are the checker's job
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pix.valid === 1'b1) got.push_back(pix.rgb);
    if (cyc == 2000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Pixels 0x123 and 0x456, lone byte, restart mid-group, refused data, then pixel 0x123
  task automatic t_groups();
    got.delete();
    i_host.send(1'b0, pwp_pkg::CMD_MEM_WRITE);
    i_host.send(1'b1, 8'h12);
    i_host.send(1'b1, 8'h34);
    i_host.send(1'b1, 8'h56);
    i_host.send(1'b1, 8'hab);
    i_host.send(1'b0, 8'h00);
    i_host.send(1'b1, 8'h77);
    i_host.send(1'b0, pwp_pkg::CMD_MEM_WRITE);
    i_host.send(1'b1, 8'h12);
    i_host.send(1'b1, 8'h34);
    i_host.idle();
    repeat (2) @(negedge clk);
    chk("count", 12'h003, 12'(got.size()));
    chk("pix0", 12'h123, got[0]);
    chk("pix1", 12'h456, got[1]);
    chk("pix2", 12'h123, got[2]);
    $display("groups done");
  endtask
  // Table holds low nibble of index as value; 8-bit bytes expand through it
  task automatic t_eight();
    logic [7:0] b;
    i_host.send(1'b0, pwp_pkg::CMD_COLOUR_SET);
    for (int i = 0; i < 20; i++) i_host.send(1'b1, 8'(i));
    i_host.idle();
    chk("busy", 12'h000, {11'h0, table_busy});
    got.delete();
    mode_8bit = 1'b1;
    i_host.send(1'b0, pwp_pkg::CMD_MEM_WRITE);
    for (int i = 0; i < 3; i++) i_host.send(1'b1, 8'h72 * 8'(i));
    i_host.idle();
    repeat (2) @(negedge clk);
    chk("lut_count", 12'h003, 12'(got.size()));
    for (int i = 0; i < 3; i++) begin
      b = 8'h72 * 8'(i);
      chk("lut", {1'b0, b[7:5], 1'b1, b[4:2], 2'h0, b[1:0]}, got[i]);
    end
    $display("eight done");
  endtask
  // Reset mid-load: busy drops, table clears, a byte then expands to zero
  task automatic t_reset();
    i_host.send(1'b0, pwp_pkg::CMD_COLOUR_SET);
    i_host.send(1'b1, 8'h0f);
    i_host.idle();
    arst_n = 1'b0;
    @(negedge clk);
    chk("busy_rst", 12'h000, {11'h0, table_busy});
    arst_n = 1'b1;
    got.delete();
    i_host.send(1'b0, pwp_pkg::CMD_MEM_WRITE);
    i_host.send(1'b1, 8'hff);
    i_host.idle();
    repeat (2) @(negedge clk);
    chk("rst_count", 12'h001, 12'(got.size()));
    chk("rst_pix", 12'h000, got[0]);
    $display("reset done");
  endtask
  initial begin
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    t_groups();
    t_eight();
    t_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
